/* File: rtl/cam_addr_decode.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cam_params.svh"
module cam_addr_decode (
   input wire logic i_clock, // 200 MHz clock
   input wire logic i_rst_b, // Synchronous reset, active low
   input wire logic i_start, // Decode request pulse
   input wire cam_pkg::cam_mode_t i_mode, // Addressing mode
   input wire logic i_prebyte_valid, // A prebyte preceded the opcode
   input wire logic [7:0] i_prebyte, // Prebyte value
   input wire logic i_mem_to_mem, // Opcode is memory-to-memory
   input wire logic [7:0] i_index_x, // Index register X
   input wire logic [7:0] i_index_y, // Index register Y
   input wire logic [15:0] i_opcode_addr, // Address of opcode
   input wire logic i_mem_ack, // Read data valid
   input wire logic [7:0] i_mem_data, // Read data
   output logic o_mem_req, // Read request, held until ack
   output logic [15:0] o_mem_addr, // Read address
   output logic o_busy, // Decode in progress
   output logic o_done, // Result valid pulse
   output logic [15:0] o_ea, // Effective address
   output logic [7:0] o_operand, // Immediate operand
   output logic [15:0] o_target, // Branch target
   output logic [2:0] o_length, // Instruction length in bytes
   output logic o_use_y, // Index Y selected
   output logic o_form_fault // Long form on memory-to-memory op
);
   import cam_pkg::*;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_STREAM,
      ST_PTR,
      ST_CALC
   } cam_state_t;

   cam_state_t st_q;
   cam_mode_t mode_q;
   logic ysel_q;
   logic pre_q;
   logic mm_q;
   logic [7:0] idx_q;
   logic [15:0] opc_q;
   logic cnt_q;
   logic [7:0] strm_q [2];
   logic [7:0] ptr_q [2];
   logic [1:0] nstream;
   logic [1:0] nptr;
   logic [15:0] next_pc;
   logic [15:0] calc_ea;
   logic [15:0] calc_target;
   logic done_q;
   logic [15:0] ea_q;
   logic [15:0] target_q;
   logic [7:0] operand_q;
   logic [2:0] length_q;
   logic fault_q;
   logic last_strm;
   logic last_ptr;

   function automatic logic [1:0] stream_bytes(input cam_mode_t m);
      unique case (m)
         MODE_INH, MODE_IDX_N:
            stream_bytes = 2'd0;
         MODE_DIR_L, MODE_IDX_L, MODE_BTJ_D, MODE_BTJ_I:
            stream_bytes = 2'd2;
         default:
            stream_bytes = 2'd1;
      endcase
   endfunction

   function automatic logic [1:0] ptr_bytes(input cam_mode_t m);
      unique case (m)
         MODE_IND_L, MODE_IIDX_L:
            ptr_bytes = 2'd2;
         MODE_IND_S, MODE_IIDX_S, MODE_REL_I, MODE_BIT_I, MODE_BTJ_I:
            ptr_bytes = 2'd1;
         default:
            ptr_bytes = 2'd0;
      endcase
   endfunction

   function automatic logic is_long(input cam_mode_t m);
      is_long = (m == MODE_DIR_L) || (m == MODE_IDX_L) ||
         (m == MODE_IND_L) || (m == MODE_IIDX_L);
   endfunction

   assign nstream = stream_bytes(mode_q);
   assign nptr = ptr_bytes(mode_q);
   assign last_strm = (cnt_q == nstream[1]);
   assign last_ptr = (cnt_q == nptr[1]);
   assign next_pc = 16'(opc_q + {15'h0000, 1'b1} + {14'h0000, nstream});

   // Sequencer
   always_ff @(posedge i_clock)
   begin
      if (!i_rst_b)
         st_q <= ST_IDLE;
      else
      begin
         unique case (st_q)
            ST_IDLE:
               if (i_start)
               begin
                  if (stream_bytes(i_mode) != 2'd0)
                     st_q <= ST_STREAM;
                  else
                     st_q <= ST_CALC;
               end
            ST_STREAM:
               if (i_mem_ack && last_strm)
               begin
                  if (nptr != 2'd0)
                     st_q <= ST_PTR;
                  else
                     st_q <= ST_CALC;
               end
            ST_PTR:
               if (i_mem_ack && last_ptr)
                  st_q <= ST_CALC;
            ST_CALC:
               st_q <= ST_IDLE;
         endcase
      end
   end

   // Byte counter within a fetch phase
   always_ff @(posedge i_clock)
   begin
      if (!i_rst_b)
         cnt_q <= 1'b0;
      else if (st_q == ST_STREAM && i_mem_ack)
         cnt_q <= last_strm ? 1'b0 : 1'b1;
      else if (st_q == ST_PTR && i_mem_ack)
         cnt_q <= last_ptr ? 1'b0 : 1'b1;
   end

   // Request capture
   always_ff @(posedge i_clock)
   begin
      if (!i_rst_b)
      begin
         mode_q <= MODE_INH;
         ysel_q <= 1'b0;
         pre_q <= 1'b0;
         mm_q <= 1'b0;
         idx_q <= `CAM_RST_BYTE;
         opc_q <= `CAM_RST_WORD;
      end
      else if (st_q == ST_IDLE && i_start)
      begin
         mode_q <= i_mode;
         ysel_q <= i_prebyte_valid && (i_prebyte == `CAM_PREBYTE_Y);
         pre_q <= i_prebyte_valid;
         mm_q <= i_mem_to_mem;
         idx_q <= (i_prebyte_valid && (i_prebyte == `CAM_PREBYTE_Y)) ?
            i_index_y : i_index_x;
         opc_q <= i_opcode_addr;
      end
   end

   // Fetched bytes, in address order so the high byte lands first
   generate
      for (genvar g = 0; g < 2; g++)
      begin : g_byte
         always_ff @(posedge i_clock)
         begin
            if (!i_rst_b)
            begin
               strm_q[g] <= `CAM_RST_BYTE;
               ptr_q[g] <= `CAM_RST_BYTE;
            end
            else if (i_mem_ack && cnt_q == 1'(g))
            begin
               if (st_q == ST_STREAM)
                  strm_q[g] <= i_mem_data;
               else if (st_q == ST_PTR)
                  ptr_q[g] <= i_mem_data;
            end
         end
      end
   endgenerate

   always_comb
   begin
      o_mem_req = (st_q == ST_STREAM) || (st_q == ST_PTR);
      if (st_q == ST_PTR)
         o_mem_addr = 16'({`CAM_PAGE_ZERO, strm_q[0]} +
            {15'h0000, cnt_q});
      else
         o_mem_addr = 16'(opc_q + {15'h0000, 1'b1} + {15'h0000, cnt_q});
   end

   cam_ea_calc u_calc (
      .i_mode(mode_q),
      .i_stream0(strm_q[0]),
      .i_stream1(strm_q[1]),
      .i_ptr0(ptr_q[0]),
      .i_ptr1(ptr_q[1]),
      .i_index(idx_q),
      .i_next_pc(next_pc),
      .o_ea(calc_ea),
      .o_target(calc_target)
   );

   // Result registers
   always_ff @(posedge i_clock)
   begin
      if (!i_rst_b)
      begin
         done_q <= 1'b0;
         ea_q <= `CAM_RST_WORD;
         target_q <= `CAM_RST_WORD;
         operand_q <= `CAM_RST_BYTE;
         length_q <= `CAM_OPCODE_BYTES;
         fault_q <= 1'b0;
      end
      else
      begin
         done_q <= (st_q == ST_CALC);
         if (st_q == ST_CALC)
         begin
            ea_q <= calc_ea;
            target_q <= calc_target;
            operand_q <= strm_q[0];
            length_q <= 3'(`CAM_OPCODE_BYTES + {1'b0, nstream} +
               {2'b00, pre_q});
            fault_q <= mm_q && is_long(mode_q);
         end
      end
   end

   assign o_busy = (st_q != ST_IDLE);
   assign o_done = done_q;
   assign o_ea = ea_q;
   assign o_target = target_q;
   assign o_operand = operand_q;
   assign o_length = length_q;
   assign o_use_y = ysel_q;
   assign o_form_fault = fault_q;

   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_rst_b);

   sequence s_start_inh;
      st_q == ST_IDLE && i_start && i_mode == MODE_INH && !i_prebyte_valid;
   endsequence

   sequence s_inh_finish;
      !o_mem_req ##1 (o_done && o_length == 3'd1);
   endsequence

   a_inherent_no_fetch: assert property (s_start_inh |=> s_inh_finish)
      else $error("inherent decode fetched or wrong length");

   a_immediate_len: assert property (o_done && mode_q == MODE_IMM && !pre_q
      |-> o_length == 3'd2 && o_operand == strm_q[0])
      else $error("immediate length or operand wrong");

   a_direct_short: assert property (o_done && mode_q == MODE_DIR_S
      |-> o_ea == {8'h00, strm_q[0]})
      else $error("short direct address wrong");

   a_direct_long: assert property (o_done && mode_q == MODE_DIR_L
      |-> o_ea == {strm_q[0], strm_q[1]})
      else $error("long direct address not high byte first");

   a_noff_index: assert property (o_done && mode_q == MODE_IDX_N
      |-> o_ea == {8'h00, idx_q} &&
      o_length == (pre_q ? 3'd2 : 3'd1))
      else $error("no-offset indexed address or length wrong");

   a_short_index: assert property (o_done && mode_q == MODE_IDX_S
      |-> o_ea <= 16'h01fe &&
      o_ea == {8'h00, idx_q} + {8'h00, strm_q[0]})
      else $error("short indexed address wrong");

   a_y_select: assert property (st_q == ST_IDLE && i_start && i_prebyte_valid
      && i_prebyte == 8'h90 |=> o_use_y && idx_q == $past(i_index_y))
      else $error("Y prebyte did not select Y");

   a_ptr_page_zero: assert property (st_q == ST_PTR && o_mem_req
      |-> o_mem_addr[15:9] == 7'h00 &&
      ($past(st_q) != ST_PTR || $stable(strm_q[0])))
      else $error("pointer fetch outside pointer area");

   a_short_indirect: assert property (o_done && mode_q == MODE_IND_S
      |-> o_ea == {8'h00, ptr_q[0]})
      else $error("short indirect address wrong");

   a_rel_target: assert property (o_done && mode_q == MODE_REL_D
      |-> o_target == 16'(opc_q + 16'h0002 +
      {{8{strm_q[0][7]}}, strm_q[0]}))
      else $error("relative target wrong");

   a_long_fault: assert property (o_done && mm_q && mode_q == MODE_IND_L
      |-> o_form_fault)
      else $error("long form on memory op not flagged");

   a_done_pulse: assert property (o_done |=> !o_done)
      else $error("done held longer than one cycle");
endmodule
`default_nettype wire

/* File: pkg/cam_params.svh */
// Functional notes
// - Seventeen addressing modes in nine families
// - Long forms reach the whole 64 KB space
// - Short forms stay in page zero, except short indexed forms, which reach 1FE
// - Memory-to-memory operations use short forms only
// - Inherent instruction is one byte, no operands
// - Immediate instruction: opcode plus operand byte
// - Short direct: one address byte, 00 to FF
// - Long direct: two address bytes, full space
// - Indexed address is index plus offset, unsigned
// - No-offset indexed uses index as address
// - No-offset indexed adds one byte with Y
// - Short indexed: byte offset, reaches 00 to 1FE
// - Long indexed: word offset, full space
// - Indirect: fetch pointer address, then pointer
// - Short indirect: byte pointer, 00 to FF
// - Long indirect: word pointer, full space
// - Branch target counts from next instruction
// - Y prebyte selects index Y, adds a byte
`ifndef CAM_PARAMS_SVH
`define CAM_PARAMS_SVH
`define CAM_PAGE_ZERO 8'h00
`define CAM_PREBYTE_Y 8'h90
`define CAM_OPCODE_BYTES 3'h1
`define CAM_RST_WORD 16'h0000
`define CAM_RST_BYTE 8'h00
`define CAM_SHORT_IDX_MAX 16'h01fe
`endif

/* File: pkg/cam_pkg.sv */
`default_nettype none
package cam_pkg;
   typedef enum logic [4:0] {
      MODE_INH,
      MODE_IMM,
      MODE_DIR_S,
      MODE_DIR_L,
      MODE_IDX_N,
      MODE_IDX_S,
      MODE_IDX_L,
      MODE_IND_S,
      MODE_IND_L,
      MODE_IIDX_S,
      MODE_IIDX_L,
      MODE_REL_D,
      MODE_REL_I,
      MODE_BIT_D,
      MODE_BIT_I,
      MODE_BTJ_D,
      MODE_BTJ_I
   } cam_mode_t;
endpackage
`default_nettype wire

/* File: rtl/cam_ea_calc.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cam_params.svh"
module cam_ea_calc (
   input wire cam_pkg::cam_mode_t i_mode, // Addressing mode
   input wire logic [7:0] i_stream0, // First byte after opcode
   input wire logic [7:0] i_stream1, // Second byte after opcode
   input wire logic [7:0] i_ptr0, // First pointer byte
   input wire logic [7:0] i_ptr1, // Second pointer byte
   input wire logic [7:0] i_index, // Selected index value
   input wire logic [15:0] i_next_pc, // Address of next instruction
   output logic [15:0] o_ea, // Effective address
   output logic [15:0] o_target // Branch target
);
   import cam_pkg::*;
   logic [8:0] sum_s;
   logic [8:0] sum_p;
   logic [7:0] rel;

   assign sum_s = {1'b0, i_index} + {1'b0, i_stream0};
   assign sum_p = {1'b0, i_index} + {1'b0, i_ptr0};

   always_comb
   begin
      o_ea = `CAM_RST_WORD;
      rel = i_stream0;
      unique case (i_mode)
         MODE_INH, MODE_IMM:
            o_ea = `CAM_RST_WORD;
         MODE_DIR_S, MODE_BIT_D:
            o_ea = {`CAM_PAGE_ZERO, i_stream0};
         MODE_BTJ_D:
         begin
            o_ea = {`CAM_PAGE_ZERO, i_stream0};
            rel = i_stream1;
         end
         MODE_DIR_L:
            o_ea = {i_stream0, i_stream1};
         MODE_IDX_N:
            o_ea = {`CAM_PAGE_ZERO, i_index};
         MODE_IDX_S:
            o_ea = {7'h00, sum_s};
         MODE_IDX_L:
            o_ea = 16'({i_stream0, i_stream1} + {8'h00, i_index});
         MODE_IND_S, MODE_BIT_I:
            o_ea = {`CAM_PAGE_ZERO, i_ptr0};
         MODE_BTJ_I:
         begin
            o_ea = {`CAM_PAGE_ZERO, i_ptr0};
            rel = i_stream1;
         end
         MODE_IND_L:
            o_ea = {i_ptr0, i_ptr1};
         MODE_IIDX_S:
            o_ea = {7'h00, sum_p};
         MODE_IIDX_L:
            o_ea = 16'({i_ptr0, i_ptr1} + {8'h00, i_index});
         MODE_REL_D:
            rel = i_stream0;
         MODE_REL_I:
            rel = i_ptr0;
      endcase
   end

   // Sign extend offset onto next instruction address
   assign o_target = 16'(i_next_pc + {{8{rel[7]}}, rel});
endmodule
`default_nettype wire

/* File: verification/cam_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module cam_mem_model (
   input wire logic i_clock, // Clock
   input wire logic i_mem_req, // Read request
   input wire logic [15:0] i_mem_addr, // Read address
   input wire logic i_slow, // Two wait cycles per byte
   output logic o_mem_ack, // Byte valid
   output logic [7:0] o_mem_data // Read byte
);
   logic [1:0] wait_q = 2'h0;
   logic [7:0] last_q = 8'h00;
   always_comb
   begin
      o_mem_ack = i_mem_req && (wait_q == (i_slow ? 2'h2 : 2'h0));
      // Idle bus shows inverse of last byte
      o_mem_data = o_mem_ack ? (i_mem_addr[7:0] ^ i_mem_addr[15:8] ^ 8'ha5)
         : ~last_q;
   end
   always_ff @(posedge i_clock)
   begin
      wait_q <= (i_mem_req && !o_mem_ack) ? wait_q + 2'h1 : 2'h0;
      if (o_mem_ack)
      begin
         last_q <= o_mem_data;
      end
   end
endmodule
`default_nettype wire

/* File: verification/cam_addr_decode_test.sv */
`timescale 1ns/1ps
`default_nettype none
module cam_addr_decode_test;
   import cam_pkg::*;
   typedef struct {
      cam_mode_t m;
      logic pv;
      logic [7:0] pb;
      logic m2m;
      logic [15:0] opc;
      logic [7:0] x;
      logic [7:0] y;
      logic [2:0] len;
      logic flt;
   } cam_row_t;
   logic i_clock = 1'b0;
   logic i_rst_b = 1'b0;
   logic i_start = 1'b0;
   cam_mode_t i_mode = MODE_INH;
   logic i_prebyte_valid = 1'b0;
   logic [7:0] i_prebyte = 8'h00;
   logic i_mem_to_mem = 1'b0;
   logic [7:0] i_index_x = 8'h00;
   logic [7:0] i_index_y = 8'h00;
   logic [15:0] i_opcode_addr = 16'h0000;
   logic i_slow = 1'b0;
   logic i_mem_ack;
   logic [7:0] i_mem_data;
   logic o_mem_req, o_busy, o_done, o_use_y, o_form_fault;
   logic [15:0] o_mem_addr, o_ea, o_target;
   logic [7:0] o_operand;
   logic [2:0] o_length;
   int failures = 0;
   int checks = 0;
   cam_row_t rows [18];
   always #2.5 i_clock = ~i_clock;
   cam_addr_decode cam_addr_decode_i (.i_clock(i_clock), .i_rst_b(i_rst_b),
      .i_start(i_start), .i_mode(i_mode), .i_prebyte_valid(i_prebyte_valid),
      .i_prebyte(i_prebyte), .i_mem_to_mem(i_mem_to_mem),
      .i_index_x(i_index_x), .i_index_y(i_index_y),
      .i_opcode_addr(i_opcode_addr), .i_mem_ack(i_mem_ack),
      .i_mem_data(i_mem_data), .o_mem_req(o_mem_req),
      .o_mem_addr(o_mem_addr), .o_busy(o_busy), .o_done(o_done),
      .o_ea(o_ea), .o_operand(o_operand), .o_target(o_target),
      .o_length(o_length), .o_use_y(o_use_y), .o_form_fault(o_form_fault));
   cam_mem_model cam_mem_model_i (.i_clock(i_clock), .i_mem_req(o_mem_req),
      .i_mem_addr(o_mem_addr), .i_slow(i_slow), .o_mem_ack(i_mem_ack),
      .o_mem_data(i_mem_data));
   function automatic logic [7:0] mb(input logic [15:0] a);
      return a[7:0] ^ a[15:8] ^ 8'ha5;
   endfunction
   task automatic chk(input string nm, input logic [15:0] e, g);
      checks++;
      if (g !== e)
      begin
         failures++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic go(input cam_row_t r);
      @(negedge i_clock);
      i_mode = r.m;
      i_prebyte_valid = r.pv;
      i_prebyte = r.pb;
      i_mem_to_mem = r.m2m;
      i_opcode_addr = r.opc;
      i_index_x = r.x;
      i_index_y = r.y;
      i_start = 1'b1;
      @(negedge i_clock);
      i_start = 1'b0;
   endtask
   task automatic wt(input cam_row_t r);
      logic [7:0] s0, s1, p0, p1, ix, off;
      logic [15:0] ea, tg;
      int n;
      n = 0;
      while (n < 60)
      begin
         @(posedge i_clock);
         #1;
         if (o_done === 1'b1)
            break;
         chk("busy", 16'h1, {15'h0, o_busy});
         n++;
      end
      chk("done wait", 16'h0, {15'h0, n == 60});
      chk("busy at done", 16'h0, {15'h0, o_busy});
      s0 = mb(r.opc + 16'h1);
      s1 = mb(r.opc + 16'h2);
      p0 = mb({8'h00, s0});
      p1 = mb({8'h00, s0} + 16'h1);
      ix = (r.pv && r.pb == 8'h90) ? r.y : r.x;
      case (r.m)
         MODE_DIR_S, MODE_BIT_D, MODE_BTJ_D: ea = {8'h00, s0};
         MODE_DIR_L: ea = {s0, s1};
         MODE_IDX_N: ea = {8'h00, ix};
         MODE_IDX_S: ea = {8'h00, s0} + {8'h00, ix};
         MODE_IDX_L: ea = {s0, s1} + {8'h00, ix};
         MODE_IND_S, MODE_BIT_I, MODE_BTJ_I: ea = {8'h00, p0};
         MODE_IND_L: ea = {p0, p1};
         MODE_IIDX_S: ea = {8'h00, p0} + {8'h00, ix};
         MODE_IIDX_L: ea = {p0, p1} + {8'h00, ix};
         default: ea = 16'h0000;
      endcase
      off = (r.m == MODE_REL_D) ? s0 : (r.m == MODE_REL_I) ? p0 : s1;
      tg = r.opc + {13'h0, r.len} - {15'h0, r.pv} + {{8{off[7]}}, off};
      if (r.m inside {MODE_IND_S, MODE_IND_L, MODE_IIDX_S, MODE_IIDX_L,
         MODE_BIT_I, MODE_BTJ_I})
         chk("ptr ea", ea, o_ea);
      else
         chk("ea", ea, o_ea);
      if (r.m inside {MODE_REL_D, MODE_REL_I, MODE_BTJ_D, MODE_BTJ_I})
         chk("target", tg, o_target);
      if (r.m == MODE_IMM)
         chk("operand", {8'h0, s0}, {8'h0, o_operand});
      chk("length", {13'h0, r.len}, {13'h0, o_length});
      chk("use_y", {15'h0, r.pv && r.pb == 8'h90}, {15'h0, o_use_y});
      chk("fault", {15'h0, r.flt}, {15'h0, o_form_fault});
   endtask
   initial
   begin
      #20000;
      failures++;
      complete_run();
   end
   initial
   begin
      rows = '{
         '{MODE_INH, 1'b0, 8'h00, 1'b0, 16'h0100, 8'h00, 8'h00, 3'h1, 1'b0},
         '{MODE_IMM, 1'b0, 8'h00, 1'b0, 16'h0200, 8'h00, 8'h00, 3'h2, 1'b0},
         '{MODE_DIR_S, 1'b0, 8'h00, 1'b1, 16'h0310, 8'h00, 8'h00, 3'h2, 1'b0},
         '{MODE_DIR_L, 1'b0, 8'h00, 1'b1, 16'hf0e0, 8'h00, 8'h00, 3'h3, 1'b1},
         '{MODE_IDX_N, 1'b0, 8'h00, 1'b0, 16'h0400, 8'h37, 8'h11, 3'h1, 1'b0},
         '{MODE_IDX_N, 1'b1, 8'h90, 1'b0, 16'h0400, 8'h37, 8'hc8, 3'h2, 1'b0},
         '{MODE_IDX_S, 1'b0, 8'h00, 1'b0, 16'h0059, 8'hff, 8'h00, 3'h2, 1'b0},
         '{MODE_IDX_L, 1'b1, 8'h90, 1'b1, 16'h1234, 8'h01, 8'h80, 3'h4, 1'b1},
         '{MODE_IND_S, 1'b1, 8'h92, 1'b0, 16'h0520, 8'h00, 8'h00, 3'h3, 1'b0},
         '{MODE_IND_L, 1'b1, 8'h92, 1'b1, 16'h7a00, 8'h00, 8'h00, 3'h3, 1'b1},
         '{MODE_IIDX_S, 1'b1, 8'h91, 1'b0, 16'h0630, 8'hff, 8'h22, 3'h3, 1'b0},
         '{MODE_IIDX_L, 1'b1, 8'h92, 1'b1, 16'h0740, 8'h9c, 8'h00, 3'h3, 1'b1},
         '{MODE_REL_D, 1'b0, 8'h00, 1'b0, 16'h0850, 8'h00, 8'h00, 3'h2, 1'b0},
         '{MODE_REL_I, 1'b1, 8'h92, 1'b0, 16'h0960, 8'h00, 8'h00, 3'h3, 1'b0},
         '{MODE_BIT_D, 1'b0, 8'h00, 1'b1, 16'h0a70, 8'h00, 8'h00, 3'h2, 1'b0},
         '{MODE_BIT_I, 1'b1, 8'h92, 1'b1, 16'h0b80, 8'h00, 8'h00, 3'h3, 1'b0},
         '{MODE_BTJ_D, 1'b0, 8'h00, 1'b1, 16'h0c90, 8'h00, 8'h00, 3'h3, 1'b0},
         '{MODE_BTJ_I, 1'b1, 8'h92, 1'b1, 16'h0da0, 8'h00, 8'h00, 3'h4, 1'b0}};
      repeat (20) @(negedge i_clock);
      i_rst_b = 1'b1;
      chk("rst length", 16'h1, {13'h0, o_length});
      chk("rst addr", 16'h0001, o_mem_addr);
      chk("rst ea", 16'h0, o_ea);
      chk("rst flags", 16'h0,
         {11'h000, o_busy, o_mem_req, o_done, o_use_y, o_form_fault});
      for (int s = 0; s < 2; s++)
      begin
         i_slow = s[0];
         foreach (rows[k])
         begin
            go(rows[k]);
            wt(rows[k]);
         end
      end
      // Back-to-back start, then a start while busy
      go(rows[3]);
      wt(rows[3]);
      go(rows[8]);
      @(negedge i_clock);
      i_mode = MODE_INH;
      i_start = 1'b1;
      @(negedge i_clock);
      i_start = 1'b0;
      wt(rows[8]);
      repeat (8)
      begin
         @(posedge i_clock);
         #1;
         chk("extra done", 16'h0, {15'h0, o_done});
      end
      // Reset in mid-fetch
      go(rows[9]);
      @(negedge i_clock);
      i_rst_b = 1'b0;
      repeat (2) @(negedge i_clock);
      chk("mid rst", 16'h0, {13'h0000, o_busy, o_mem_req, o_done});
      chk("mid rst length", 16'h1, {13'h0, o_length});
      i_rst_b = 1'b1;
      go(rows[0]);
      wt(rows[0]);
      complete_run();
   end
endmodule
`default_nettype wire
